//--- bench/acdc_far_model.sv
// Far side: analog core and DMA controller.
// One latency input paces both the conversion and the DMA acks.
module acdc_far_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Analog core
  input wire logic conv_start_i,
  input wire logic [11:0] sample_i,
  input wire logic [3:0] lat_i,
  output logic conv_done_o,
  output logic [11:0] conv_data_o,
  // DMA
  input wire logic dma_req_i,
  output logic dma_ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_r;
  logic [3:0] wait_r;
  wire fin = cnt_r == 5'h01;
  wire want = dma_req_i && !dma_ack_o;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= 5'h00;
      wait_r <= 4'h0;
      conv_done_o <= 1'b0;
      dma_ack_o <= 1'b0;
      conv_data_o <= 12'h000;
    end else begin
      conv_done_o <= fin;
      // Data only meaningful with the strobe, so it toggles otherwise
      conv_data_o <= fin ? sample_i : ~conv_data_o;
      if (conv_start_i) begin
        cnt_r <= {1'b0, lat_i} + 5'h02;
      end else if (cnt_r != 5'h00) begin
        cnt_r <= cnt_r - 5'h01;
      end
      dma_ack_o <= want && wait_r >= lat_i;
      wait_r <= (want && wait_r < lat_i) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule

//--- bench/acdc_top_assertions.sv
// Port-level checks for acdc_top.
// Bound to every acdc_top instance; reads its ports only.
module acdc_top_checker
  import acdc_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Inputs
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic power_down_i,
  input wire logic dma_ack_i,
  // Outputs
  input wire logic analog_power_o,
  input wire logic conv_start_o,
  input wire logic [2:0] conv_clock_select_o,
  input wire logic dma_req_o,
  input wire logic [7:0] dma_data_o,
  input wire logic dma_last_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  wire ctl_wr = sfr_wr_i && sfr_addr_i == ACDC_CTRL_ADDR;
  wire cfg_wr = sfr_wr_i && sfr_addr_i == ACDC_CFG0_ADDR;
  wire take = dma_req_o && dma_ack_i;
  a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse too long");
  a_start_powered: assert property (conv_start_o |-> analog_power_o)
    else $error("start while unpowered");
  a_pd_no_start: assert property (
    power_down_i && $past(power_down_i) |-> !conv_start_o)
    else $error("start in power-down");
  a_power_follow: assert property (
    ctl_wr |-> ##2 analog_power_o ==
      ($past(sfr_wdata_i[7], 2) && !$past(power_down_i)))
    else $error("power not following enable bit");
  a_clksel_copy: assert property (
    cfg_wr |-> ##2 conv_clock_select_o == $past(sfr_wdata_i[7:5], 2))
    else $error("clock select mismatch");
  a_dma_hold: assert property (
    dma_req_o && !dma_ack_i |=> dma_req_o && $stable(dma_data_o))
    else $error("dma byte changed before ack");
  a_low_then_high: assert property (
    take && !dma_last_o |=> dma_req_o && dma_last_o)
    else $error("second byte missing");
  a_last_ends: assert property (take && dma_last_o |=> !dma_req_o)
    else $error("request after last byte");
  c_two_byte: cover property (take && !dma_last_o);
  c_start: cover property (conv_start_o);
  c_pd: cover property (power_down_i && ctl_wr);
endmodule

bind acdc_top acdc_top_checker i_chk (
  .clock_i(clock_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i),
  .power_down_i(power_down_i), .dma_ack_i(dma_ack_i),
  .analog_power_o(analog_power_o), .conv_start_o(conv_start_o),
  .conv_clock_select_o(conv_clock_select_o), .dma_req_o(dma_req_o),
  .dma_data_o(dma_data_o), .dma_last_o(dma_last_o));

//--- bench/tb.sv
// Bench for acdc_top: register bus stimulus, far model, checks.
// One 100 MHz clock; conversions and DMA acks come from the model.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import acdc_pkg::*;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic sfr_wr_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [2:0] ev = 3'h0;
  logic tick = 1'b0;
  logic pd = 1'b0;
  logic [11:0] sample = 12'h000;
  logic [3:0] lat = 4'h0;
  logic [7:0] sfr_rdata_o, dma_data_o, v, q;
  logic [11:0] conv_data_i;
  logic [4:0] mux_select_o;
  logic [2:0] conv_clock_select_o;
  logic conv_done_i, dma_ack_i, dma_req_o, dma_last_o, irq, power, start;
  logic [7:0] got[$];
  logic [3:0] c;
  int fails = 0;
  int samples_checked = 0;
  int starts = 0;
  int s0;
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    tick <= #1 1'($urandom);
    if (start) starts++;
    if (dma_req_o && dma_ack_i) got.push_back(dma_data_o);
  end
  acdc_top i_dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_wr_i(sfr_wr_i), .sfr_rdata_o(sfr_rdata_o),
    .timer0_ovf_i(ev[0]), .brg_ovf_i(ev[1]), .conv_clk_tick_i(tick),
    .window_match_i(ev[2]), .power_down_i(pd), .conv_done_i(conv_done_i),
    .conv_data_i(conv_data_i), .analog_power_o(power), .conv_start_o(start),
    .mux_select_o(mux_select_o), .conv_clock_select_o(conv_clock_select_o),
    .converter_irq_o(irq), .dma_ack_i(dma_ack_i), .dma_req_o(dma_req_o),
    .dma_data_o(dma_data_o), .dma_last_o(dma_last_o));
  acdc_far_model i_far (
    .clock_i(clock_i), .resetn_i(resetn_i), .conv_start_i(start),
    .sample_i(sample), .lat_i(lat), .conv_done_o(conv_done_i),
    .conv_data_o(conv_data_i), .dma_req_i(dma_req_o), .dma_ack_o(dma_ack_i));
  task automatic chk(input string what, input logic [15:0] exp, act);
    samples_checked++;
    if (act !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, act);
    end
  endtask
  task automatic wrap_up();
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Every task starts and ends 1 ns after a rising edge
  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    idle(1);
    sfr_wr_i = 1'b0;
    idle(2);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr_i = a;
    idle(2);
    d = sfr_rdata_o;
  endtask
  task automatic pulse(input logic [2:0] e);
    ev = e;
    idle(1);
    ev = 3'h0;
  endtask
  task automatic do_reset();
    resetn_i = 1'b0;
    pd = 1'b0;
    idle(3);
    resetn_i = 1'b1;
  endtask
  task automatic power_up();
    wr(ACDC_CTRL_ADDR, 8'h80);
    idle(500);
    chk("power on", 16'h1, 16'(power));
  endtask
  function automatic logic [3:0] nxt(input logic [15:0] m,
                                     input logic [3:0] cur);
    for (int i = 1; i <= 16; i++) begin
      if (m[4'(cur + i)]) return 4'(cur + i);
    end
    return cur;
  endfunction
  task automatic conv(input logic [7:0] c0, c3, input logic [11:0] s);
    logic [11:0] t;
    logic [15:0] p;
    int n;
    sample = s;
    lat = 4'($urandom);
    t = s & ~((12'h1 << {c3[3:2], 1'b0}) - 12'h1);
    p = c0[ACDC_RJ_BIT] ? 16'(t >> {c3[3:2], 1'b0}) : {t, 4'h0};
    n = c3[ACDC_DBS_BIT] ? 1 : 2;
    got.delete();
    wr(ACDC_CFG0_ADDR, c0);
    wr(ACDC_CFG3_ADDR, c3);
    // Read back first so the scan channel bits survive the write
    rd(ACDC_CTRL_ADDR, v);
    wr(ACDC_CTRL_ADDR, v | 8'h08);
    for (int i = 0; i < 300 && got.size() < n; i++) idle(1);
    idle(4);
    chk("byte count", 16'(n), 16'(got.size()));
    v = c0[ACDC_RJ_BIT] ? p[7:0] : p[15:8];
    if (n == 2) chk("two bytes", p, {got[1], got[0]});
    else chk("one byte", 16'(v), 16'(got[0]));
    rd(ACDC_CTRL_ADDR, v);
    chk("done, start", 16'h2, 16'(v[4:3]));
    chk("done irq", 16'h1, 16'(irq));
    s0 = starts;
    wr(ACDC_CTRL_ADDR, v | 8'h08);
    idle(30);
    chk("start refused", 16'(s0), 16'(starts));
    wr(ACDC_CTRL_ADDR, v & 8'hE7);
  endtask
  initial begin
    void'($urandom(71));
    do_reset();
    rd(ACDC_CTRL_ADDR, v);
    chk("ctrl reset", 16'(ACDC_CTRL_RST), 16'(v));
    rd(ACDC_CFG3_ADDR, v);
    chk("cfg3 reset", 16'(ACDC_CFG3_RST), 16'(v));
    wr(8'hD0, 8'hFF);
    rd(8'hD0, v);
    chk("unmapped", 16'h0, 16'(v));
    power_up();
    for (int k = 0; k < 18; k++) begin
      wr(ACDC_CFG0_ADDR, {4'h0, k > 15, 3'h0});
      wr(ACDC_CTRL_ADDR, {2'b10, k[3], 2'b00, k[2:0]});
      chk("mux select", 16'({k > 15, k[3:0]}), 16'(mux_select_o));
    end
    wr(ACDC_CFG1_ADDR, 8'h40);
    pulse(3'b100);
    rd(ACDC_CTRL_ADDR, v);
    chk("window flag", 16'h1, 16'(v[6]));
    chk("window irq", 16'h1, 16'(irq));
    wr(ACDC_CTRL_ADDR, v & 8'hBF);
    rd(ACDC_CTRL_ADDR, v);
    chk("window clear", 16'h0, 16'(v[6]));
    for (int i = 0; i < 24; i++) begin
      v = {3'($urandom), i[0], 4'h0};
      q = {4'h0, 2'(i / 2 % 3), i % 12 >= 6, 1'b1};
      conv(v, q, i < 12 ? 12'hFFF : 12'($urandom));
    end
    wr(ACDC_SCANL_ADDR, 8'h21);
    wr(ACDC_SCANH_ADDR, 8'h84);
    c = mux_select_o[3:0];
    for (int k = 0; k < 6; k++) begin
      conv(8'h00, 8'h01, 12'($urandom));
      c = nxt(16'h8421, c);
      chk("scan channel", 16'(c), 16'(mux_select_o));
    end
    wr(ACDC_SCANL_ADDR, 8'h00);
    wr(ACDC_SCANH_ADDR, 8'h00);
    conv(8'h00, 8'h01, 12'($urandom));
    chk("scan stopped", 16'(c), 16'(mux_select_o));
    wr(ACDC_CTRL_ADDR, 8'h00);
    chk("power off", 16'h0, 16'(power));
    pd = 1'b1;
    s0 = starts;
    wr(ACDC_CTRL_ADDR, 8'h88);
    idle(40);
    chk("power-down start", 16'(s0), 16'(starts));
    // Hardware triggers may re-run, so each mode starts from a reset
    for (int m = 1; m < 4; m++) begin
      do_reset();
      power_up();
      wr(ACDC_CFG0_ADDR, 8'(m));
      wr(ACDC_CFG3_ADDR, 8'h01);
      s0 = starts;
      wr(ACDC_CTRL_ADDR, 8'h88);
      idle(20);
      chk("early start", 16'(m == 2), 16'(starts > s0));
      pulse(m == 1 ? 3'b001 : m == 3 ? 3'b010 : 3'b000);
      idle(20);
      chk("trigger start", 16'h1, 16'(starts > s0));
    end
    wrap_up();
  end
  initial begin
    #300000;
    chk("watchdog", 16'h0, 16'h1);
    wrap_up();
  end
endmodule

//--- verilog/acdc_pkg.sv
// Package for the converter scan and DMA control block.
// Assumes an 8-bit special-function register bus with one-cycle strobes.
package acdc_pkg;
  // Register offsets on the special-function register bus
  localparam logic [7:0] ACDC_CTRL_ADDR = 8'hC4;
  localparam logic [7:0] ACDC_CFG0_ADDR = 8'hC3;
  localparam logic [7:0] ACDC_RESL_ADDR = 8'hC5;
  localparam logic [7:0] ACDC_RESH_ADDR = 8'hC6;
  localparam logic [7:0] ACDC_CFG1_ADDR = 8'hC7;
  localparam logic [7:0] ACDC_CFG3_ADDR = 8'hC8;
  localparam logic [7:0] ACDC_SCANL_ADDR = 8'hC9;
  localparam logic [7:0] ACDC_SCANH_ADDR = 8'hCA;
  // Control register fields
  localparam int ACDC_EN_BIT = 7;
  localparam int ACDC_WIN_BIT = 6;
  localparam int ACDC_CHMSB_BIT = 5;
  localparam int ACDC_DONE_BIT = 4;
  localparam int ACDC_START_BIT = 3;
  // Configuration 0 fields
  localparam int ACDC_CKS_LSB = 5;
  localparam int ACDC_RJ_BIT = 4;
  localparam int ACDC_AUX_BIT = 3;
  // Configuration 1 fields
  localparam int ACDC_IGN_BIT = 7;
  localparam int ACDC_WIE_BIT = 6;
  // Configuration 3 fields
  localparam int ACDC_TMX_LSB = 6;
  localparam int ACDC_RES_LSB = 2;
  localparam int ACDC_DBS_BIT = 1;
  localparam int ACDC_DMAEN_BIT = 0;
  // Reset values
  localparam logic [7:0] ACDC_CTRL_RST = 8'h00;
  localparam logic [7:0] ACDC_CFG0_RST = 8'h00;
  localparam logic [7:0] ACDC_CFG1_RST = 8'h00;
  localparam logic [7:0] ACDC_CFG3_RST = 8'h40;
  localparam logic [7:0] ACDC_SCAN_RST = 8'h00;
  // Trigger sources and resolutions
  localparam logic [1:0] ACDC_TRIG_SW = 2'h0;
  localparam logic [1:0] ACDC_TRIG_T0 = 2'h1;
  localparam logic [1:0] ACDC_TRIG_FREE = 2'h2;
  localparam logic [1:0] ACDC_TRIG_BRG = 2'h3;
  localparam logic [1:0] ACDC_RES_12 = 2'h0;
  localparam logic [1:0] ACDC_RES_10 = 2'h1;
  // Conversion length in conversion clocks
  localparam logic [5:0] ACDC_CONV_CLKS = 6'h1E;
  typedef enum logic [1:0] {ACDC_IDLE, ACDC_CONV, ACDC_DMA_LO, ACDC_DMA_HI}
    acdc_state_t;
endpackage

//--- verilog/acdc_scan_next.sv
// Next-channel finder for the scan mode.
// Pure combinational; the caller registers the result.
module acdc_scan_next (
  // Scan state
  input wire logic [15:0] mask_i,
  input wire logic [3:0] cur_i,
  // Result
  output logic [3:0] next_o
);
  logic [15:0] above;
  logic [3:0] hi_pick [0:16];
  logic [3:0] lo_pick [0:16];
  logic [16:0] hi_any;
  logic [16:0] lo_any;
  // Channels strictly above the current one
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_bit
      assign above[g] = (4'(g) > cur_i) && mask_i[g];
      // Search from the top so the lowest match wins
      assign hi_pick[g] = above[g] ? 4'(g) : hi_pick[g+1];
      assign hi_any[g] = above[g] | hi_any[g+1];
      assign lo_pick[g] = mask_i[g] ? 4'(g) : lo_pick[g+1];
      assign lo_any[g] = mask_i[g] | lo_any[g+1];
    end
  endgenerate
  assign hi_pick[16] = 4'h0;
  assign lo_pick[16] = 4'h0;
  assign hi_any[16] = 1'b0;
  assign lo_any[16] = 1'b0;
  // Wrap to lowest enabled channel
  assign next_o = hi_any[0] ? hi_pick[0] : (lo_any[0] ? lo_pick[0] : cur_i);
endmodule

//--- verilog/acdc_top.sv
// Converter control, scan sequencing and DMA result formatting.
// Assumes the analog core reports conversion end via a strobe; the
// window comparator, timers and clock divider sit outside and feed
// their events in as synchronous one-cycle pulses.
//
// Summary of operation
// - Scan advances channel after each finished conversion
// - Empty scan mask stops channel switching
// - Scan mask split over two byte registers
// - Four-bit trigger mode field; only its low two bits select start
// - DMA sends low byte then high byte
// - Resolution truncates low bits to zero
// - Byte-count bit picks two or one bytes
// - Single byte transfer picks significant byte
// - Full-scale byte order follows justification table
// - Control bit 7 powers converter on
// - Window flag set by hardware, cleared by software
// - Done flag requests interrupt unless ignored
// - Start bit cleared only by hardware or by clearing control bit 7
// - No new conversion while start low or done high
// - Channel is bit 5 plus bits 2..0
// - Auxiliary select picks reference or ground
// - No conversions in power-down
// - Idle conversion completes and can wake CPU
// - Basic trigger bits choose start source
// - Justification bit places result left or right
// - Resolution encoding 12, 10, 8, reserved
// - Clock select field drives conversion clock
module acdc_top (
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Register bus
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  output logic [7:0] sfr_rdata_o,
  // Trigger and event pulses, power-down level
  input wire logic timer0_ovf_i,
  input wire logic brg_ovf_i,
  input wire logic conv_clk_tick_i,
  input wire logic window_match_i,
  input wire logic power_down_i,
  // Analog core
  input wire logic conv_done_i,
  input wire logic [11:0] conv_data_i,
  output logic analog_power_o,
  output logic conv_start_o,
  output logic [4:0] mux_select_o,
  output logic [2:0] conv_clock_select_o,
  // Interrupt requests
  output logic converter_irq_o,
  // DMA
  input wire logic dma_ack_i,
  output logic dma_req_o,
  output logic [7:0] dma_data_o,
  output logic dma_last_o
);
  import acdc_pkg::*;

  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] cfg0_r, cfg1_r, cfg3_r;
  logic [7:0] scan_lo_r, scan_hi_r;
  logic [7:0] res_lo_r, res_hi_r;
  logic [7:0] rdata_r;
  logic [4:0] mux_r;
  logic start_pulse_r, irq_r;
  logic [5:0] conv_cnt_r;
  logic dma_req_r, dma_last_r;
  logic [7:0] dma_data_r;
  acdc_state_t state_r, state_nxt;

  // Register decode
  wire wr_ctrl = sfr_wr_i && (sfr_addr_i == ACDC_CTRL_ADDR);
  wire wr_cfg0 = sfr_wr_i && (sfr_addr_i == ACDC_CFG0_ADDR);
  wire wr_cfg1 = sfr_wr_i && (sfr_addr_i == ACDC_CFG1_ADDR);
  wire wr_cfg3 = sfr_wr_i && (sfr_addr_i == ACDC_CFG3_ADDR);
  wire wr_scl = sfr_wr_i && (sfr_addr_i == ACDC_SCANL_ADDR);
  wire wr_sch = sfr_wr_i && (sfr_addr_i == ACDC_SCANH_ADDR);

  wire enabled = ctrl_r[ACDC_EN_BIT];
  wire start_bit = ctrl_r[ACDC_START_BIT];
  wire done_flag = ctrl_r[ACDC_DONE_BIT];
  wire [15:0] scan_mask = {scan_hi_r, scan_lo_r};
  wire scan_on = |scan_mask;
  wire [3:0] chan = {ctrl_r[ACDC_CHMSB_BIT], ctrl_r[2:0]};
  wire aux_sel = cfg0_r[ACDC_AUX_BIT];
  wire right_j = cfg0_r[ACDC_RJ_BIT];
  wire [1:0] res_sel = cfg3_r[ACDC_RES_LSB +: 2];
  wire one_byte = cfg3_r[ACDC_DBS_BIT];
  wire dma_en = cfg3_r[ACDC_DMAEN_BIT];
  wire [3:0] trig_mode = {cfg3_r[ACDC_TMX_LSB +: 2], cfg0_r[1:0]};
  wire [1:0] trig_base = trig_mode[1:0];

  // Hardware start source; extension bits only widen the field here
  wire hw_trig = (trig_base == ACDC_TRIG_T0) ? timer0_ovf_i :
                 (trig_base == ACDC_TRIG_FREE) ? 1'b1 :
                 (trig_base == ACDC_TRIG_BRG) ? brg_ovf_i : 1'b0;
  // Software start needs the start bit; other modes rerun once armed
  wire may_start = enabled && !power_down_i && start_bit &&
                   (trig_base == ACDC_TRIG_SW || hw_trig);
  // Done flag must be gone before another start
  wire go = (state_r == ACDC_IDLE) && may_start && !done_flag;
  // Conversion ends on core strobe or after the nominal clock count
  wire conv_end = (state_r == ACDC_CONV) &&
    (conv_done_i || (conv_clk_tick_i && conv_cnt_r == ACDC_CONV_CLKS));

  // Result formatting: truncate then justify
  wire [11:0] keep_mask = (res_sel == ACDC_RES_12) ? 12'hFFF :
                          (res_sel == ACDC_RES_10) ? 12'hFFC : 12'hFF0;
  wire [11:0] trunc = conv_data_i & keep_mask;
  wire [11:0] rj_val = (res_sel == ACDC_RES_12) ? trunc :
                       (res_sel == ACDC_RES_10) ? {2'h0, trunc[11:2]} :
                       {4'h0, trunc[11:4]};
  wire [15:0] fmt = right_j ? {4'h0, rj_val} : {trunc, 4'h0};
  // Single byte: the one holding the data, low when right-justified
  wire [7:0] single_b = right_j ? fmt[7:0] : fmt[15:8];

  // Next scan channel
  logic [3:0] scan_next;
  acdc_scan_next u_next (
    .mask_i(scan_mask),
    .cur_i(chan),
    .next_o(scan_next)
  );

  // Control register update
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = sfr_wdata_i;
      // Start bit only settable, flags only clearable
      // A start written while done is high is dropped, not queued
      ctrl_nxt[ACDC_START_BIT] = start_bit |
        (sfr_wdata_i[ACDC_START_BIT] & ~done_flag);
      ctrl_nxt[ACDC_WIN_BIT] = ctrl_r[ACDC_WIN_BIT] &
                               sfr_wdata_i[ACDC_WIN_BIT];
      ctrl_nxt[ACDC_DONE_BIT] = done_flag & sfr_wdata_i[ACDC_DONE_BIT];
    end
    // Disabling the converter drops any pending start
    if (!ctrl_nxt[ACDC_EN_BIT])
      ctrl_nxt[ACDC_START_BIT] = 1'b0;
    if (conv_end) begin
      // Software trigger is single shot; others keep the start bit set
      if (trig_base == ACDC_TRIG_SW)
        ctrl_nxt[ACDC_START_BIT] = 1'b0;
      ctrl_nxt[ACDC_DONE_BIT] = 1'b1;
      if (scan_on) begin
        ctrl_nxt[ACDC_CHMSB_BIT] = scan_next[3];
        ctrl_nxt[2:0] = scan_next[2:0];
      end
    end
    // Set wins over a same-cycle clear
    if (window_match_i && enabled)
      ctrl_nxt[ACDC_WIN_BIT] = 1'b1;
  end

  // State machine
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ACDC_IDLE: if (go) state_nxt = ACDC_CONV;
      ACDC_CONV: begin
        // Losing power mid conversion drops the result
        if (!enabled || power_down_i)
          state_nxt = ACDC_IDLE;
        else if (conv_end)
          state_nxt = dma_en ? ACDC_DMA_LO : ACDC_IDLE;
      end
      ACDC_DMA_LO: if (dma_ack_i)
        state_nxt = one_byte ? ACDC_IDLE : ACDC_DMA_HI;
      ACDC_DMA_HI: if (dma_ack_i) state_nxt = ACDC_IDLE;
      default: state_nxt = ACDC_IDLE;
    endcase
  end

  // DMA byte presented in each transfer state
  // High byte comes from the stored result, which holds until idle
  wire [7:0] dma_byte_nxt = (state_nxt == ACDC_DMA_HI) ? res_hi_r :
    (state_nxt == ACDC_DMA_LO && state_r == ACDC_CONV) ?
      (one_byte ? single_b : fmt[7:0]) : dma_data_r;
  wire dma_req_nxt = (state_nxt == ACDC_DMA_LO) ||
                     (state_nxt == ACDC_DMA_HI);
  wire dma_last_nxt = (state_nxt == ACDC_DMA_HI) ||
                      (state_nxt == ACDC_DMA_LO && one_byte);

  // Follow the next channel so the mux never lags a scan step
  wire [3:0] chan_nxt = {ctrl_nxt[ACDC_CHMSB_BIT], ctrl_nxt[2:0]};
  // Auxiliary codes 0 and 1 map to reference and ground
  // Reserved auxiliary codes fall back to the reference
  wire [4:0] mux_nxt = aux_sel ? {1'b1, 3'h0, chan_nxt == 4'h1} :
                                 {1'b0, chan_nxt};

  // Interrupt request
  wire irq_nxt = (ctrl_nxt[ACDC_DONE_BIT] & ~cfg1_r[ACDC_IGN_BIT]) |
                 (ctrl_nxt[ACDC_WIN_BIT] & cfg1_r[ACDC_WIE_BIT]);

  // Read mux
  // Registered, so data follows the address by one cycle
  wire [7:0] rd_nxt =
    (sfr_addr_i == ACDC_CTRL_ADDR) ? ctrl_r :
    (sfr_addr_i == ACDC_CFG0_ADDR) ? cfg0_r :
    (sfr_addr_i == ACDC_RESL_ADDR) ? res_lo_r :
    (sfr_addr_i == ACDC_RESH_ADDR) ? res_hi_r :
    (sfr_addr_i == ACDC_CFG1_ADDR) ? cfg1_r :
    (sfr_addr_i == ACDC_CFG3_ADDR) ? cfg3_r :
    (sfr_addr_i == ACDC_SCANL_ADDR) ? scan_lo_r :
    (sfr_addr_i == ACDC_SCANH_ADDR) ? scan_hi_r : 8'h00;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_r <= ACDC_CTRL_RST;
      cfg0_r <= ACDC_CFG0_RST;
      cfg1_r <= ACDC_CFG1_RST;
      cfg3_r <= ACDC_CFG3_RST;
      scan_lo_r <= ACDC_SCAN_RST;
      scan_hi_r <= ACDC_SCAN_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
      if (wr_cfg0) cfg0_r <= sfr_wdata_i;
      if (wr_cfg1) cfg1_r <= sfr_wdata_i;
      if (wr_cfg3) cfg3_r <= sfr_wdata_i & 8'hCF;
      if (wr_scl) scan_lo_r <= sfr_wdata_i;
      if (wr_sch) scan_hi_r <= sfr_wdata_i;
    end
  end

  // Result store on conversion end
  // Held through both DMA bytes; a new start waits for idle
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      res_lo_r <= 8'h00;
      res_hi_r <= 8'h00;
    end else if (conv_end) begin
      res_lo_r <= fmt[7:0];
      res_hi_r <= fmt[15:8];
    end
  end

  // Conversion sequencing
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= ACDC_IDLE;
      conv_cnt_r <= 6'h00;
      start_pulse_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      start_pulse_r <= go;
      if (go)
        conv_cnt_r <= 6'h00;
      else if (state_r == ACDC_CONV && conv_clk_tick_i)
        conv_cnt_r <= conv_cnt_r + 6'h01;
    end
  end

  // Output flops
  // Every output leaves a flop, so the bus sees no combinational path
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dma_req_r <= 1'b0;
      dma_last_r <= 1'b0;
      dma_data_r <= 8'h00;
      mux_r <= 5'h00;
      irq_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      dma_req_r <= dma_req_nxt;
      dma_last_r <= dma_last_nxt;
      dma_data_r <= dma_byte_nxt;
      mux_r <= mux_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rd_nxt;
    end
  end

  // Clock select and power copies for the analog side
  logic [7:0] cks_r;
  logic pwr_r;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cks_r <= 8'h00;
      pwr_r <= 1'b0;
    end else begin
      cks_r <= {5'h00, cfg0_r[ACDC_CKS_LSB +: 3]};
      pwr_r <= ctrl_nxt[ACDC_EN_BIT] & ~power_down_i;
    end
  end

  assign sfr_rdata_o = rdata_r;
  assign analog_power_o = pwr_r;
  assign conv_start_o = start_pulse_r;
  assign mux_select_o = mux_r;
  assign conv_clock_select_o = cks_r[2:0];
  assign converter_irq_o = irq_r;
  assign dma_req_o = dma_req_r;
  assign dma_data_o = dma_data_r;
  assign dma_last_o = dma_last_r;
endmodule
